// file: bench/test_adc_result_coherency_ctrl.sv
/*
  Self-checking bench for arc_ctrl: register reads and writes, results in
  all modes, byte coherency, interrupt paths, asynchronous conversion clock.
  Assumes the sample input may change every cycle; each result is checked
  against the repeating nibble pattern that the bench drives.
*/
`timescale 1ns/1ps
module test_adc_result_coherency_ctrl
  import arc_pkg::*;
;
  logic        ref_clk;
  logic        rst_n;
  logic        clk_en;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        async_clk;
  logic [3:0]  pat;
  logic [4:0]  conv_channel;
  logic        conv_busy;
  logic        irq;
  logic [7:0]  h;
  logic [7:0]  l;
  logic [7:0]  l0;
  int          mismatches;
  int          n_compared;
  int          cyc;
  int          n;

  arc_ctrl #(.RES_W(12)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .async_clk(async_clk),
    .conv_sample({3{pat}}), .conv_channel(conv_channel),
    .conv_busy(conv_busy), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Unrelated to the bus clock on purpose, about 5.6 bus cycles per tick
  initial begin
    async_clk = 1'b0;
    forever #70 async_clk = ~async_clk;
  end
  // Sample changes every cycle so stale or mixed bytes show up
  always @(posedge ref_clk) begin
    pat <= pat + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(d, e);
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 check({7'h0, irq}, {7'h0, e});
    @(posedge ref_clk);
  endtask
  task automatic wait_done();
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (conv_busy !== 1'b0 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 1000) mismatches++;
  endtask
  // Both bytes must carry one sample: nibble repeated across the word
  task automatic chk_res(input logic [1:0] m);
    rd(ARC_RESH_OFS, h);
    rd(ARC_RESL_OFS, l);
    case (m)
      ARC_MODE_8: begin
        check(h, 8'h00);
        check(l, {l[3:0], l[3:0]});
      end
      ARC_MODE_12: begin
        check(h, {4'h0, l[3:0]});
        check(l, {l[3:0], l[3:0]});
      end
      default: begin
        check(h, {6'h0, l[5:4]});
        check(l, {l[3:2], l[5:2], l[5:4]});
      end
    endcase
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0; clk_en = 1'b1; reg_addr = 4'h0; reg_wdata = 8'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; pat = 4'h0; cyc = 0;
    mismatches = 0; n_compared = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(ARC_SC1_OFS, ARC_SC1_RST);
    rdc(ARC_CFG_OFS, ARC_CFG_RST);
    rdc(ARC_STAT_OFS, 8'h00);
    rdc(ARC_MASK_OFS, 8'h00);
    rdc(4'hf, 8'h00);
    wr(ARC_SC1_OFS, 8'h9f); // Flag bit is read-only
    rdc(ARC_SC1_OFS, 8'h1f);
    // 8-bit single conversion, interrupt on, channel 3
    wr(ARC_SC1_OFS, 8'h43);
    wait_done();
    chk_irq(1'b1);
    rdc(ARC_SC1_OFS, 8'hc3);
    check({3'h0, conv_channel}, 8'h03);
    rdc(ARC_STAT_OFS, 8'h01);
    chk_res(ARC_MODE_8);
    l0 = l;
    repeat (60) @(posedge ref_clk);
    rdc(ARC_RESL_OFS, l0);
    // Rewrite clears the flag and the enabled interrupt with it
    wr(ARC_SC1_OFS, 8'h03);
    rdc(ARC_SC1_OFS, 8'h03);
    wr(ARC_STAT_OFS, 8'h01);
    chk_irq(1'b0);
    wait_done();
    chk_irq(1'b0);
    wr(ARC_MASK_OFS, 8'h01);
    chk_irq(1'b1);
    wr(ARC_STAT_OFS, 8'h01);
    chk_irq(1'b0);
    rdc(ARC_STAT_OFS, 8'h00);
    wr(ARC_MASK_OFS, 8'h00);
    // Continuous runs; read phase against completion is swept by 0 to 23 idle cycles
    for (int m = 1; m <= 2; m++) begin
      wr(ARC_CFG_OFS, {6'h0, m[1:0]});
      wr(ARC_SC1_OFS, 8'h25);
      for (int k = 0; k < 24; k++) begin
        repeat (k) @(posedge ref_clk);
        chk_res(m[1:0]);
      end
      wr(ARC_SC1_OFS, 8'h1f);
      repeat (4) @(posedge ref_clk);
      check({7'h0, conv_busy}, 8'h00);
      rdc(ARC_SC1_OFS, 8'h1f);
    end
    wr(ARC_STAT_OFS, 8'h03);
    // Asynchronous source: 20 slow ticks take far more bus cycles
    wr(ARC_CFG_OFS, {5'h0, 1'b1, ARC_MODE_12});
    wr(ARC_SC1_OFS, 8'h07);
    // Enable low freezes the running conversion
    clk_en <= 1'b0;
    repeat (200) @(posedge ref_clk);
    check({7'h0, conv_busy}, 8'h01);
    clk_en <= 1'b1;
    wait_done();
    check({7'h0, n > 60}, 8'h01);
    rdc(ARC_SC1_OFS, 8'h87);
    chk_res(ARC_MODE_12);
    tally_and_finish();
  end
endmodule

// file: hdl/arc_ctrl.sv
/*
  Converter control and result coherency: status/control one, config,
  result bytes with high-then-low freeze, sticky status and interrupt.
  Assumes an analog sample word on conv_sample when a conversion ends,
  and a byte-wide register port with read data one cycle later.
*/
`timescale 1ns/1ps
module arc_ctrl
  import arc_pkg::*;
#(
  parameter int RES_W = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             async_clk,
  input  wire logic [RES_W-1:0] conv_sample,
  output logic      [4:0]       conv_channel,
  output logic                  conv_busy,
  output logic                  irq
);
  typedef struct packed {
    logic [7:0]       sc1;
    logic [7:0]       cfg;
    logic             busy;
    logic [4:0]       cnt;
    logic [RES_W-1:0] result;
    logic [7:0]       low_frz;
    logic             frozen;
    logic             pend_v;
    logic [RES_W-1:0] pend;
    logic [1:0]       stat;
    logic [1:0]       mask;
    logic [7:0]       rdata;
    logic             irq;
  } arc_st_t;

  arc_st_t  st_ff;
  arc_st_t  nxt_st;
  arc_bus_t bus;
  logic     tick;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  arc_tick u_tick (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .use_async (st_ff.cfg[ARC_CFG_CLK_BIT]),
    .async_clk (async_clk),
    .tick      (tick)
  );

  // Aligned 16-bit view of the result for the chosen mode
  function automatic logic [15:0] arc_align(input logic [1:0] m,
                                            input logic [RES_W-1:0] v);
    logic [15:0] w;
    w = 16'(v);
    if (m == ARC_MODE_8) begin
      arc_align = {8'h00, w[11:4]};
    end else if (m == ARC_MODE_10) begin
      arc_align = {6'h00, w[11:2]};
    end else begin
      arc_align = {4'h0, w[11:0]};
    end
  endfunction

  logic        wide;
  logic        done;
  logic        sc1_wr;
  logic        rd_hi;
  logic        rd_lo;
  logic [15:0] cur;
  logic [1:0]  evt;

  assign wide   = st_ff.cfg[1:0] != ARC_MODE_8;
  assign done   = st_ff.busy && tick && st_ff.cnt == 5'h01;
  assign sc1_wr = bus.wr && bus.addr == ARC_SC1_OFS;
  assign rd_hi  = bus.rd && bus.addr == ARC_RESH_OFS;
  assign rd_lo  = bus.rd && bus.addr == ARC_RESL_OFS;
  assign cur    = arc_align(st_ff.cfg[1:0], st_ff.result);

  always_comb begin
    nxt_st = st_ff;
    evt    = 2'h0;
    // Conversion sequencing
    if (st_ff.busy && tick) begin
      nxt_st.cnt = st_ff.cnt - 5'h01;
    end
    if (done) begin
      evt[0] = 1'b1;
      // Held result while the low byte is frozen or a wide high read freezes it now, else load now
      // Narrow mode never freezes, so it must load directly
      if (st_ff.frozen || (rd_hi && wide)) begin
        nxt_st.pend_v = 1'b1;
        nxt_st.pend   = conv_sample;
        evt[1]        = st_ff.pend_v;
      end else begin
        nxt_st.result = conv_sample;
      end
      nxt_st.sc1[ARC_SC1_FLAG_BIT] = 1'b1;
      // Continuous restarts; single stays idle so result holds
      nxt_st.busy = st_ff.sc1[ARC_SC1_CONT_BIT];
      nxt_st.cnt  = ARC_CONV_TICKS;
    end
    // High byte read freezes the low byte of a wide result
    if (rd_hi && wide && !st_ff.frozen) begin
      nxt_st.frozen  = 1'b1;
      nxt_st.low_frz = cur[7:0];
    end
    if (rd_lo && st_ff.frozen) begin
      nxt_st.frozen = 1'b0;
      nxt_st.pend_v = 1'b0;
      // A result landing on the low read is newest, so it wins
      if (done) begin
        nxt_st.result = conv_sample;
      end else if (st_ff.pend_v) begin
        nxt_st.result = st_ff.pend;
      end
    end
    // Register writes
    if (sc1_wr) begin
      // Write clears the flag even when a conversion lands now
      nxt_st.sc1 = {1'b0, bus.wdata[6:0]};
      nxt_st.busy = bus.wdata[4:0] != ARC_CH_OFF;
      nxt_st.cnt  = ARC_CONV_TICKS;
      nxt_st.frozen = 1'b0;
      nxt_st.pend_v = 1'b0;
    end else if (bus.wr && bus.addr == ARC_CFG_OFS) begin
      nxt_st.cfg = bus.wdata;
    end else if (bus.wr && bus.addr == ARC_MASK_OFS) begin
      nxt_st.mask = bus.wdata[1:0];
    end
    // Sticky status, set beats write-one-to-clear
    if (bus.wr && bus.addr == ARC_STAT_OFS) begin
      nxt_st.stat = st_ff.stat & ~bus.wdata[1:0];
    end
    nxt_st.stat = nxt_st.stat | evt;
    // Read data
    nxt_st.rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr == ARC_SC1_OFS) begin
        nxt_st.rdata = st_ff.sc1;
      end else if (bus.addr == ARC_CFG_OFS) begin
        nxt_st.rdata = st_ff.cfg;
      end else if (bus.addr == ARC_RESH_OFS) begin
        nxt_st.rdata = wide ? cur[15:8] : 8'h00;
      end else if (bus.addr == ARC_RESL_OFS) begin
        nxt_st.rdata = st_ff.frozen ? st_ff.low_frz : cur[7:0];
      end else if (bus.addr == ARC_STAT_OFS) begin
        nxt_st.rdata = {6'h00, st_ff.stat};
      end else if (bus.addr == ARC_MASK_OFS) begin
        nxt_st.rdata = {6'h00, st_ff.mask};
      end
    end
    nxt_st.irq = (nxt_st.sc1[ARC_SC1_FLAG_BIT] &&
                  nxt_st.sc1[ARC_SC1_IE_BIT]) ||
                 |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.sc1    <= ARC_SC1_RST;
      st_ff.cfg    <= ARC_CFG_RST;
      st_ff.stat   <= ARC_STAT_RST;
      st_ff.mask   <= ARC_MASK_RST;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata    = st_ff.rdata;
  assign irq          = st_ff.irq;
  assign conv_busy    = st_ff.busy;
  assign conv_channel = st_ff.sc1[4:0];

  a_low_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rd_hi && wide && !st_ff.frozen |=>
      st_ff.frozen && st_ff.low_frz == $past(cur[7:0]))
    else $error("low byte not frozen on high read");
  a_pend_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done && rd_hi && wide |=> st_ff.pend_v && $stable(st_ff.result))
    else $error("result changed during high read");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done && !sc1_wr |=> st_ff.sc1[ARC_SC1_FLAG_BIT])
    else $error("complete flag not set");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && sc1_wr |=> !st_ff.sc1[ARC_SC1_FLAG_BIT])
    else $error("write did not clear flag");
  a_irq_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.sc1[ARC_SC1_FLAG_BIT] && st_ff.sc1[ARC_SC1_IE_BIT] |-> st_ff.irq)
    else $error("interrupt not requested");
  a_stop_conv: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && sc1_wr && bus.wdata[4:0] == ARC_CH_OFF |=> !st_ff.busy)
    else $error("stop write ignored");
  a_single_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_ff.busy && !st_ff.pend_v |=> $stable(st_ff.result))
    else $error("result changed while idle");
  a_eight_nofrz: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rd_hi && !wide && !st_ff.frozen |=> !st_ff.frozen)
    else $error("freeze in 8 bit mode");

  a_eight_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rd_hi && !wide |=> st_ff.rdata == 8'h00)
    else $error("high byte not zero in 8 bit mode");

  a_freeze_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.frozen && !(clk_en && (rd_lo || sc1_wr)) |=>
      st_ff.frozen && $stable(st_ff.low_frz))
    else $error("frozen low byte changed");

  a_unfreeze_lo: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rd_lo && st_ff.frozen |=> !st_ff.frozen)
    else $error("low read did not release freeze");

  a_pend_apply: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && rd_lo && st_ff.frozen && st_ff.pend_v && !done |=>
      st_ff.result == $past(st_ff.pend))
    else $error("held result not loaded on low read");

  a_load_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done && !st_ff.frozen && !(rd_hi && wide) |=>
      st_ff.result == $past(conv_sample))
    else $error("result not loaded on completion");

  a_cmpl_stat: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done |=> st_ff.stat[0])
    else $error("complete status not set");

  a_ovr_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done && st_ff.frozen && st_ff.pend_v |=> st_ff.stat[1])
    else $error("overrun not flagged");

  a_stat_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && bus.wr && bus.addr == ARC_STAT_OFS && !done |=>
      (st_ff.stat & $past(bus.wdata[1:0])) == 2'h0)
    else $error("status bit not cleared");

  a_irq_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(st_ff.sc1[ARC_SC1_FLAG_BIT] && st_ff.sc1[ARC_SC1_IE_BIT]) &&
      !(|(st_ff.stat & st_ff.mask)) |-> !st_ff.irq)
    else $error("interrupt without cause");

  a_busy_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && sc1_wr && bus.wdata[4:0] != ARC_CH_OFF |=> st_ff.busy)
    else $error("channel write did not start");

  a_single_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done && !st_ff.sc1[ARC_SC1_CONT_BIT] && !sc1_wr |=> !st_ff.busy)
    else $error("single conversion did not stop");

  a_cont_again: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && done && st_ff.sc1[ARC_SC1_CONT_BIT] && !sc1_wr |=> st_ff.busy)
    else $error("continuous conversion did not restart");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !bus.rd |=> st_ff.rdata == 8'h00)
    else $error("read data stands without read");
endmodule

// file: hdl/arc_tick.sv
/*
  Conversion tick source: bus clock or a slow asynchronous clock level.
  Assumes the async source level is already in the ref_clk domain via
  a two-stage synchroniser kept in this module.
*/
`timescale 1ns/1ps
module arc_tick
  import arc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic use_async,
  input  wire logic async_clk,
  output logic      tick
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } arc_tick_st_t;

  arc_tick_st_t st_ff;
  arc_tick_st_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = async_clk;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // Async rising edge from second stage only; bus clock ticks every cycle that clk_en is high
  assign tick = clk_en & (use_async ? (st_ff.s2 & ~st_ff.s3) : 1'b1);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end
endmodule

// file: shared/arc_pkg.sv
/*
  Package for the converter result and control block: register map,
  field positions, reset values, modes and the bus carrier struct.
  Assumes a byte-wide register port clocked by ref_clk.
*/
package arc_pkg;
  // Register offsets, byte wide
  localparam logic [3:0] ARC_SC1_OFS  = 4'h0;
  localparam logic [3:0] ARC_CFG_OFS  = 4'h1;
  localparam logic [3:0] ARC_RESH_OFS = 4'h2;
  localparam logic [3:0] ARC_RESL_OFS = 4'h3;
  localparam logic [3:0] ARC_STAT_OFS = 4'h4;
  localparam logic [3:0] ARC_MASK_OFS = 4'h5;
  // Status/control one fields
  localparam int ARC_SC1_FLAG_BIT = 7;
  localparam int ARC_SC1_IE_BIT   = 6;
  localparam int ARC_SC1_CONT_BIT = 5;
  localparam logic [4:0] ARC_CH_OFF = 5'h1f;
  localparam logic [7:0] ARC_SC1_RST = 8'h1f;
  // Configuration fields: [1:0] mode, [2] clock select
  localparam int ARC_CFG_CLK_BIT = 2;
  localparam logic [7:0] ARC_CFG_RST = 8'h00;
  // Status bits: [0] complete event, [1] overrun (result dropped)
  localparam logic [1:0] ARC_STAT_RST = 2'h0;
  localparam logic [1:0] ARC_MASK_RST = 2'h0;
  // Conversion length in conversion clock ticks
  localparam logic [4:0] ARC_CONV_TICKS = 5'h14;

  typedef enum logic [1:0] {
    ARC_MODE_8  = 2'h0,
    ARC_MODE_12 = 2'h1,
    ARC_MODE_10 = 2'h2
  } arc_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } arc_bus_t;
endpackage
